// File: common/acls_params.svh
`ifndef ACLS_PARAMS_SVH
`define ACLS_PARAMS_SVH

// ********************************************************************
// Register byte offsets.
// ********************************************************************
`define ACLS_REG_CTRL    5'h00
`define ACLS_REG_LEN     5'h04
`define ACLS_REG_PASSES  5'h08
`define ACLS_REG_WIDX    5'h0c
`define ACLS_REG_ENTRY   5'h10
`define ACLS_REG_STATUS  5'h14
`define ACLS_REG_RES     5'h18

// ********************************************************************
// Control register bit positions.
// ********************************************************************
`define ACLS_C_START     0
`define ACLS_C_RETRIG    1
`define ACLS_C_STOP      2
`define ACLS_C_CONT      4
`define ACLS_C_BIPOLAR   8
`define ACLS_C_DIFF      9
`define ACLS_C_DYN_EN    10

// ********************************************************************
// Status register bit positions.
// ********************************************************************
`define ACLS_S_BUSY      0
`define ACLS_S_PAUSED    1
`define ACLS_S_OVR       2
`define ACLS_S_CERR      3
`define ACLS_S_PASS      8
`define ACLS_S_PTR       16

// ********************************************************************
// Channel numbers, widths and bus constants.
// ********************************************************************
`define ACLS_DIG_CHAN    6'h20
`define ACLS_SE_LAST     6'h1f
`define ACLS_DIFF_LAST   6'h0f
`define ACLS_ENTRY_W     11
`define ACLS_DIO_W       16
`define ACLS_BE_ALL      4'hf
`define ACLS_RD_ZERO     32'h0000_0000

`endif

// File: common/acls_pkg.sv
`include "acls_params.svh"

package acls_pkg;

  // One list entry as software writes it into the list memory.
  typedef struct packed {
    logic [1:0] dout;
    logic       inhibit;
    logic [1:0] gain;
    logic [5:0] chan;
  } acls_entry_t;

  // One kept sample handed to the data path.
  typedef struct packed {
    logic [5:0]             chan;
    logic [`ACLS_DIO_W-1:0] data;
  } acls_sample_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_ARMED,
    ST_CONV,
    ST_PAUSE
  } acls_state_t;

endpackage

// File: src/acls_sync2.sv
// Two-stage synchroniser for pins that arrive from outside the clock.
module acls_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output      logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// File: src/acls_list_mem.sv
// Channel list storage with one write port and a registered read port.
module acls_list_mem #(
  parameter int W     = 11,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic          clock,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output      logic [W-1:0]  rdata
);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] rdata_q;

  // Read data lag the address by one clock, as a block RAM would.
  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
    rdata_q <= mem_q[raddr];
  end

  assign rdata = rdata_q;

endmodule

// File: src/acls_seq.sv
`include "acls_params.svh"

// Overview of operation
// RQ1: Software writes a channel list of up to 1,024 entries.
// RQ2: A scan walks entries in order from first to last.
// RQ3: Triggered mode repeats the whole list up to 256 passes per trigger.
// RQ4: Analog channels valid 0..31 single-ended, 0..15 differential.
// RQ5: Any entry order, single entries and repeated channels are accepted.
// RQ6: Inhibited entries have their sample discarded after conversion.
// RQ7: Channel 32 samples the 16 digital lines as one sample.
// RQ8: Channel 32 may sit anywhere, repeated, sequenced like analog.
// RQ9: Software puts an analog threshold trigger channel in entry zero.
// RQ10: With dynamic output enabled each entry drives its 2-bit code.
// RQ11: Dynamic lines are 0 at power-up; board reset leaves them.
// RQ12: Code bit 0 drives line 0, bit 1 drives line 1, one is high.
// RQ13: Unipolar or bipolar range is one setting for the whole block.
// RQ14: Each entry carries its own gain code for the gain stage.
// RQ15: Software programs gain 1 for every channel 32 entry.
// RQ16: Result width is fixed by the board variant, read-only.
// RQ17: Each sample clock tick advances exactly one list entry.
// RQ18: Continuous mode wraps to the first entry until stopped.
// RQ19: Retriggered mode idles after its passes until the next retrigger.
// RQ20: Every trigger or retrigger restarts at entry zero.
module acls_seq #(
  parameter int DEPTH    = 1024,
  parameter int AW       = 10,
  parameter int PASS_W   = 8,
  parameter int RES_BITS = 12
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   por,
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output      logic [31:0]            avs_readdata,
  output      logic                   avs_waitrequest,
  input  wire logic                   sample_clk_n,
  input  wire logic [`ACLS_DIO_W-1:0] dio_in,
  output      logic                   adc_start,
  input  wire logic                   adc_done,
  input  wire logic [`ACLS_DIO_W-1:0] adc_data,
  output      logic [4:0]             mux_chan,
  output      logic                   mux_diff,
  output      logic [1:0]             gain_code,
  output      logic                   ai_bipolar,
  output      logic [1:0]             dyn_out,
  output      logic                   smp_valid,
  output      acls_pkg::acls_sample_t smp
);

  // ******************************************************************
  // Declarations.
  // ******************************************************************
  acls_pkg::acls_state_t  state_q;
  acls_pkg::acls_state_t  state_d;
  acls_pkg::acls_entry_t  ent_q;
  acls_pkg::acls_entry_t  mem_ent;
  acls_pkg::acls_sample_t smp_q;
  acls_pkg::acls_sample_t smp_d;
  logic [`ACLS_ENTRY_W-1:0] mem_rdata;
  logic [AW-1:0]          len_q;
  logic [AW-1:0]          widx_q;
  logic [AW-1:0]          ptr_q;
  logic [AW-1:0]          ptr_d;
  logic [PASS_W-1:0]      passes_q;
  logic [PASS_W-1:0]      pass_q;
  logic [PASS_W-1:0]      pass_d;
  logic                   cont_q;
  logic                   bip_q;
  logic                   diff_q;
  logic                   dyn_en_q;
  logic                   ovr_q;
  logic                   cerr_q;
  logic                   rd_ack_q;
  logic [31:0]            rdata_q;
  logic                   adc_start_q;
  logic                   smp_valid_q;
  logic [4:0]             mux_chan_q;
  logic [1:0]             gain_q;
  logic [1:0]             dyn_q;
  logic                   sclk_s;
  logic                   sclk_d_q;
  logic [`ACLS_DIO_W-1:0] dio_s;
  logic                   finish;

  // ******************************************************************
  // Pin synchronisers.
  // ******************************************************************

  // The sample clock and the digital lines come from outside the clock.
  acls_sync2 #(
    .W (1)
  ) u_sync_clk (
    .clock (clock),
    .rst   (rst),
    .din   (sample_clk_n),
    .dout  (sclk_s)
  );

  acls_sync2 #(
    .W (`ACLS_DIO_W)
  ) u_sync_dio (
    .clock (clock),
    .rst   (rst),
    .din   (dio_in),
    .dout  (dio_s)
  );

  // Conversions start on the falling edge of the sample clock.
  always_ff @(posedge clock)
  begin
    if (rst)
      sclk_d_q <= 1'b0;
    else
      sclk_d_q <= sclk_s;
  end

  wire tick = sclk_d_q & ~sclk_s;

  // ******************************************************************
  // Register bus decode.
  // ******************************************************************

  // Partial-word writes are ignored so no field is ever half updated.
  wire wr_ok    = avs_write & (avs_byteenable == `ACLS_BE_ALL);
  wire w_ctrl   = wr_ok & (avs_address == `ACLS_REG_CTRL);
  wire w_len    = wr_ok & (avs_address == `ACLS_REG_LEN);
  wire w_passes = wr_ok & (avs_address == `ACLS_REG_PASSES);
  wire w_widx   = wr_ok & (avs_address == `ACLS_REG_WIDX);
  wire w_entry  = wr_ok & (avs_address == `ACLS_REG_ENTRY);
  wire w_status = wr_ok & (avs_address == `ACLS_REG_STATUS);

  // Command bits are pulses; they are never stored.
  wire start_p  = w_ctrl & avs_writedata[`ACLS_C_START];
  wire retrig_p = w_ctrl & avs_writedata[`ACLS_C_RETRIG];
  wire stop_p   = w_ctrl & avs_writedata[`ACLS_C_STOP];
  wire clr_ovr  = w_status & avs_writedata[`ACLS_S_OVR];
  wire clr_cerr = w_status & avs_writedata[`ACLS_S_CERR];

  // Reads wait one cycle so that read data always come from a flop.
  assign avs_waitrequest = avs_read & ~rd_ack_q;
  assign avs_readdata    = rdata_q;

  // ******************************************************************
  // Register readback.
  // ******************************************************************
  wire busy   = (state_q != acls_pkg::ST_IDLE);
  wire paused = (state_q == acls_pkg::ST_PAUSE);

  wire [31:0] ctrl_rd =
    (32'(cont_q)   << `ACLS_C_CONT)    |
    (32'(bip_q)    << `ACLS_C_BIPOLAR) |
    (32'(diff_q)   << `ACLS_C_DIFF)    |
    (32'(dyn_en_q) << `ACLS_C_DYN_EN);

  wire [31:0] status_rd =
    (32'(busy)   << `ACLS_S_BUSY)   |
    (32'(paused) << `ACLS_S_PAUSED) |
    (32'(ovr_q)  << `ACLS_S_OVR)    |
    (32'(cerr_q) << `ACLS_S_CERR)   |
    (32'(pass_q) << `ACLS_S_PASS)   |
    (32'(ptr_q)  << `ACLS_S_PTR);

  // The result width is a build constant and cannot be written.
  wire [31:0] res_rd = 32'(RES_BITS); // see RQ16

  wire [31:0] rd_mux =
    (avs_address == `ACLS_REG_CTRL)   ? ctrl_rd :
    (avs_address == `ACLS_REG_LEN)    ? 32'(len_q) :
    (avs_address == `ACLS_REG_PASSES) ? 32'(passes_q) :
    (avs_address == `ACLS_REG_WIDX)   ? 32'(widx_q) :
    (avs_address == `ACLS_REG_STATUS) ? status_rd :
    (avs_address == `ACLS_REG_RES)    ? res_rd :
    `ACLS_RD_ZERO;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_ack_q <= 1'b0;
      rdata_q  <= `ACLS_RD_ZERO;
    end
    else
    begin
      rd_ack_q <= avs_read & ~rd_ack_q;
      rdata_q  <= rd_mux;
    end
  end

  // ******************************************************************
  // Configuration registers.
  // ******************************************************************

  // Range is one bit for the whole subsystem, not per entry.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cont_q   <= 1'b0;
      bip_q    <= 1'b0;
      diff_q   <= 1'b0;
      dyn_en_q <= 1'b0;
    end
    else if (w_ctrl)
    begin
      cont_q   <= avs_writedata[`ACLS_C_CONT];
      bip_q    <= avs_writedata[`ACLS_C_BIPOLAR]; // see RQ13
      diff_q   <= avs_writedata[`ACLS_C_DIFF];
      dyn_en_q <= avs_writedata[`ACLS_C_DYN_EN];
    end
  end

  // Entry writes auto-increment the write index for fast list loading.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      len_q    <= '0;
      passes_q <= '0;
      widx_q   <= '0;
    end
    else
    begin
      if (w_len)
        len_q <= avs_writedata[AW-1:0]; // see RQ1
      if (w_passes)
        passes_q <= avs_writedata[PASS_W-1:0]; // see RQ3
      if (w_widx)
        widx_q <= avs_writedata[AW-1:0];
      else if (w_entry)
        widx_q <= widx_q + 1'b1; // see RQ1
    end
  end

  // ******************************************************************
  // Channel list memory.
  // ******************************************************************
  acls_list_mem #(
    .W     (`ACLS_ENTRY_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_list (
    .clock (clock),
    .we    (w_entry),
    .waddr (widx_q),
    .wdata (avs_writedata[`ACLS_ENTRY_W-1:0]),
    .raddr (ptr_q),
    .rdata (mem_rdata)
  );

  assign mem_ent = acls_pkg::acls_entry_t'(mem_rdata);

  // ******************************************************************
  // Entry classification.
  // ******************************************************************

  // Any channel order is fine; only the number itself is checked.
  wire is_dig  = (mem_ent.chan == `ACLS_DIG_CHAN); // see RQ5
  wire ana_lim = diff_q ? (mem_ent.chan <= `ACLS_DIFF_LAST)
                        : (mem_ent.chan <= `ACLS_SE_LAST); // see RQ4
  wire armed   = (state_q == acls_pkg::ST_ARMED);
  wire step    = armed & tick; // see RQ17
  wire go_dig  = step & is_dig; // see RQ8
  wire go_ana  = step & ~is_dig & ana_lim;
  wire go_bad  = step & ~is_dig & ~ana_lim; // see RQ4
  wire conv_ok = (state_q == acls_pkg::ST_CONV) & adc_done;

  // A tick during a scan (busy, not paused) that finds no armed entry is an overrun and is lost.
  wire lost = tick & busy & ~armed & ~paused;

  // ******************************************************************
  // Sequencer next-state logic.
  // ******************************************************************
  always_comb
  begin
    state_d = state_q;
    ptr_d   = ptr_q;
    pass_d  = pass_q;
    finish  = 1'b0;
    case (state_q)
      acls_pkg::ST_IDLE:
      begin
        if (start_p)
        begin
          ptr_d   = '0; // see RQ20
          pass_d  = '0;
          state_d = acls_pkg::ST_FETCH;
        end
      end
      acls_pkg::ST_FETCH:
        state_d = acls_pkg::ST_ARMED;
      acls_pkg::ST_ARMED:
      begin
        if (go_ana)
          state_d = acls_pkg::ST_CONV;
        else if (go_dig | go_bad)
          finish = 1'b1; // see RQ8
      end
      acls_pkg::ST_CONV:
      begin
        if (adc_done)
          finish = 1'b1;
      end
      acls_pkg::ST_PAUSE:
      begin
        if (retrig_p)
        begin
          ptr_d   = '0; // see RQ20
          pass_d  = '0; // see RQ19
          state_d = acls_pkg::ST_FETCH;
        end
      end
      default:
        state_d = acls_pkg::ST_IDLE;
    endcase

    // One entry done: step, wrap, count a pass, or pause.
    if (finish)
    begin
      state_d = acls_pkg::ST_FETCH;
      if (ptr_q != len_q)
        ptr_d = ptr_q + 1'b1; // see RQ2
      else if (cont_q)
        ptr_d = '0; // see RQ18
      else if (pass_q != passes_q)
      begin
        ptr_d  = '0; // see RQ3
        pass_d = pass_q + 1'b1;
      end
      else
        state_d = acls_pkg::ST_PAUSE; // see RQ19
    end

    // A stop wins over everything else, even mid-conversion.
    if (stop_p)
      state_d = acls_pkg::ST_IDLE;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= acls_pkg::ST_IDLE;
      ptr_q   <= '0;
      pass_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      ptr_q   <= ptr_d;
      pass_q  <= pass_d;
    end
  end

  // The entry is held while its conversion runs.
  always_ff @(posedge clock)
  begin
    if (rst)
      ent_q <= '0;
    else if (step)
      ent_q <= mem_ent;
  end

  // ******************************************************************
  // Converter front end.
  // ******************************************************************

  // Mux and gain follow the armed entry so they settle before the tick.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mux_chan_q  <= '0;
      gain_q      <= '0;
      adc_start_q <= 1'b0;
    end
    else
    begin
      if (armed)
      begin
        mux_chan_q <= mem_ent.chan[4:0];
        gain_q     <= mem_ent.gain; // see RQ14
      end
      adc_start_q <= go_ana; // see RQ17
    end
  end

  assign mux_chan   = mux_chan_q;
  assign mux_diff   = diff_q;
  assign gain_code  = gain_q;
  assign ai_bipolar = bip_q; // see RQ13
  assign adc_start  = adc_start_q;

  // ******************************************************************
  // Dynamic digital outputs.
  // ******************************************************************

  // Only power-on clears these; the board reset must not disturb
  // equipment that the lines are steering.
  always_ff @(posedge clock)
  begin
    if (por)
      dyn_q <= 2'h0; // see RQ11
    else if (armed & dyn_en_q)
      dyn_q <= mem_ent.dout; // see RQ10
  end

  assign dyn_out = dyn_q; // see RQ12

  // ******************************************************************
  // Sample output and error flags.
  // ******************************************************************

  // Results narrower than the data path read as zero in the high bits.
  wire [`ACLS_DIO_W-1:0] res_mask = `ACLS_DIO_W'((1 << RES_BITS) - 1);

  wire keep_dig = go_dig & ~mem_ent.inhibit; // see RQ7
  wire keep_ana = conv_ok & ~ent_q.inhibit; // see RQ6

  always_comb
  begin
    smp_d = smp_q;
    if (keep_dig)
    begin
      smp_d.chan = mem_ent.chan;
      smp_d.data = dio_s; // see RQ7
    end
    else if (keep_ana)
    begin
      smp_d.chan = ent_q.chan;
      smp_d.data = adc_data & res_mask;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      smp_q       <= '0;
      smp_valid_q <= 1'b0;
    end
    else
    begin
      smp_q       <= smp_d;
      smp_valid_q <= keep_dig | keep_ana; // see RQ6
    end
  end

  assign smp       = smp_q;
  assign smp_valid = smp_valid_q;

  // Sticky flags: a new event in the clearing cycle keeps the flag set.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ovr_q  <= 1'b0;
      cerr_q <= 1'b0;
    end
    else
    begin
      ovr_q  <= lost | (ovr_q & ~clr_ovr);
      cerr_q <= go_bad | (cerr_q & ~clr_cerr); // see RQ4
    end
  end

endmodule

// File: sim/acls_seq_properties.sv
`include "acls_params.svh"

// ********************************************************************
// Port-level properties of the channel list sequencer.
// ********************************************************************
module acls_seq_properties #(
  parameter int RES_BITS = 12
) (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   por,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic                   avs_waitrequest,
  input wire logic                   adc_start,
  input wire logic                   adc_done,
  input wire logic [15:0]            adc_data,
  input wire logic [4:0]             mux_chan,
  input wire logic                   mux_diff,
  input wire logic [1:0]             dyn_out,
  input wire logic                   smp_valid,
  input wire acls_pkg::acls_sample_t smp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bits above the fixed resolution never reach a kept analog sample.
  localparam logic [15:0] MASK = 16'((32'h1 << RES_BITS) - 1);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // A read costs exactly one wait state.
  sequence s_rd_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // A kept conversion result is followed by its sample one cycle later.
  sequence s_analog_smp;
    smp_valid && smp.chan != `ACLS_DIG_CHAN;
  endsequence

  property p_rd_wait;
    $rose(avs_read) |-> s_rd_wait;
  endproperty
  property p_wr_nowait;
    avs_write |-> !avs_waitrequest;
  endproperty
  property p_start_pulse;
    adc_start |=> !adc_start;
  endproperty
  property p_smp_pulse;
    smp_valid |=> !smp_valid;
  endproperty
  property p_smp_cause;
    s_analog_smp |-> $past(adc_done);
  endproperty
  property p_smp_data;
    s_analog_smp |-> smp.data == ($past(adc_data) & MASK);
  endproperty
  property p_dig_noconv;
    smp_valid && smp.chan == `ACLS_DIG_CHAN |-> !$past(adc_done);
  endproperty
  property p_smp_hold;
    !$past(rst) && $changed(smp) |-> smp_valid;
  endproperty
  property p_diff_range;
    adc_start && mux_diff |-> mux_chan <= 5'h0f;
  endproperty
  // Only power-up clears the dynamic lines.
  property p_dyn_rst;
    @(posedge clock) disable iff (por) rst |=> $stable(dyn_out);
  endproperty
  property p_dyn_por;
    @(posedge clock) disable iff (1'h0) por |=> dyn_out == 2'h0;
  endproperty

  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait");
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stall");
  a_start_pulse: assert property (p_start_pulse)
    else $error("start width");
  a_smp_pulse: assert property (p_smp_pulse)
    else $error("valid width");
  a_smp_cause: assert property (p_smp_cause)
    else $error("no conversion");
  a_smp_data: assert property (p_smp_data)
    else $error("sample data");
  a_dig_noconv: assert property (p_dig_noconv)
    else $error("digital conv");
  a_smp_hold: assert property (p_smp_hold)
    else $error("sample moved");
  a_diff_range: assert property (p_diff_range)
    else $error("diff range");
  a_dyn_rst: assert property (p_dyn_rst)
    else $error("dyn on reset");
  a_dyn_por: assert property (p_dyn_por)
    else $error("dyn at power-up");
endmodule

// File: sim/acls_adc_model.sv
// ********************************************************************
// Converter model behind the multiplexer and gain stage.
// ********************************************************************
module acls_adc_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        adc_start,
  input  wire logic [4:0]  mux_chan,
  input  wire logic [1:0]  gain_code,
  output      logic        adc_done,
  output      logic [15:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;

  // Data toggles outside the done cycle; high bits test the mask.
  always_ff @(posedge clock)
  begin
    adc_done <= 1'h0;
    adc_data <= ~adc_data;
    if (rst)
    begin
      cnt_q    <= 4'h0;
      adc_data <= 16'h5a5a;
    end
    else if (adc_start)
      cnt_q <= slow ? 4'h6 : 4'h2;
    else if (cnt_q != 4'h0)
    begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1)
      begin
        adc_done <= 1'h1;
        adc_data <= {4'hf, 3'h0, mux_chan, 2'h0, gain_code};
      end
    end
  end
endmodule

// File: sim/tb_top.sv
`include "acls_params.svh"

// ********************************************************************
// Self-checking bench for the channel list sequencer.
// ********************************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RES_BITS = 12;

  logic clock = 1'h0, rst, por, avs_read, avs_write, slow;
  logic [4:0]  avs_address, mux_chan;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest, sample_clk_n, adc_start, adc_done;
  logic [15:0] dio_in, adc_data;
  logic        mux_diff, ai_bipolar, smp_valid;
  logic [1:0]  gain_code, dyn_out;
  acls_pkg::acls_sample_t smp;
  acls_pkg::acls_sample_t got[$], expq[$];
  acls_pkg::acls_entry_t  ent[4];
  int fails = 0;
  int tests_run = 0;

  // The clock runs at 40 MHz.
  always #12.5 clock = ~clock;

  acls_seq #(.RES_BITS(RES_BITS)) uut (.*);

  acls_adc_model u_adc (.*);

  // Kept samples are queued.
  always @(posedge clock)
    if (smp_valid === 1'h1)
      got.push_back(smp);

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_smp();
    chk("sample_count", 32'(expq.size()), 32'(got.size()));
    foreach (expq[i])
      if (i < got.size())
        chk("sample", 32'(expq[i]), 32'(got[i]));
    got.delete();
    expq.delete();
  endtask

  // One transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask

  task automatic load(input int n);
    logic [31:0] q;
    bus(1'h1, `ACLS_REG_LEN, 32'(n - 1), q);
    bus(1'h1, `ACLS_REG_WIDX, 32'h0, q);
    for (int i = 0; i < n; i++)
      bus(1'h1, `ACLS_REG_ENTRY, 32'(ent[i]), q);
  endtask

  function automatic acls_pkg::acls_sample_t exp_smp(
    acls_pkg::acls_entry_t e);
    acls_pkg::acls_sample_t s;
    s.chan = e.chan;
    s.data = (e.chan == `ACLS_DIG_CHAN) ? dio_in
           : {7'h00, e.chan[4:0], 2'h0, e.gain};
    return s;
  endfunction

  // With dyn set, checks entry outputs (dyn only for channel 32), then one sample clock fall.
  task automatic tick(input acls_pkg::acls_entry_t e, input logic dyn);
    logic [8:0] m;
    m = !dyn ? 9'h000 : (e.chan == `ACLS_DIG_CHAN) ? 9'h180 : 9'h1ff;
    repeat (3) @(posedge clock);
    @(negedge clock);
    if (m != 9'h000)
      chk("dyn_gain_mux", 32'({e.dout, e.gain, e.chan[4:0]} & m),
          32'({dyn_out, gain_code, mux_chan} & m));
    @(posedge clock);
    sample_clk_n <= 1'h0;
    repeat (2) @(posedge clock);
    sample_clk_n <= 1'h1;
    repeat (14) @(posedge clock);
  endtask

  task automatic scan(input int n, input int passes, input logic dyn,
                      input logic diff);
    for (int p = 0; p < passes; p++)
      for (int i = 0; i < n; i++)
      begin
        tick(ent[i], dyn);
        if (!ent[i].inhibit && (ent[i].chan == `ACLS_DIG_CHAN ||
            ent[i].chan <= (diff ? 6'h0f : 6'h1f)))
          expq.push_back(exp_smp(ent[i]));
      end
  endtask

  task automatic test_regs();
    logic [31:0] q;
    bus(1'h0, `ACLS_REG_CTRL, 32'h0, q);
    chk("ctrl_reset", 32'h0, q);
    bus(1'h1, `ACLS_REG_RES, 32'h0, q);
    bus(1'h0, `ACLS_REG_RES, 32'h0, q);
    chk("resolution", 32'(RES_BITS), q);
    bus(1'h0, 5'h1c, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask

  task automatic test_triggered();
    logic [31:0] q;
    ent[0] = {2'h2, 1'h0, 2'h1, 6'h05};
    ent[1] = {2'h0, 1'h0, 2'h0, 6'h20};
    ent[2] = {2'h1, 1'h1, 2'h3, 6'h07};
    ent[3] = {2'h3, 1'h0, 2'h2, 6'h05};
    load(4);
    bus(1'h1, `ACLS_REG_PASSES, 32'h1, q);
    bus(1'h1, `ACLS_REG_CTRL, 32'h0000_0501, q);
    scan(4, 2, 1'h1, 1'h0);
    chk_smp();
    chk("bipolar", 32'h1, 32'(ai_bipolar));
    bus(1'h0, `ACLS_REG_STATUS, 32'h0, q);
    chk("paused", 32'h1, 32'(q[`ACLS_S_PAUSED]));
    bus(1'h1, `ACLS_REG_CTRL, 32'h0000_0502, q);
    scan(4, 2, 1'h1, 1'h0);
    chk_smp();
    bus(1'h1, `ACLS_REG_CTRL, 32'h0000_0504, q);
  endtask

  task automatic test_continuous();
    logic [31:0] q;
    ent[0] = {2'h1, 1'h0, 2'h0, 6'h0f};
    ent[1] = {2'h2, 1'h0, 2'h0, 6'h10};
    load(2);
    slow <= 1'h1;
    bus(1'h1, `ACLS_REG_CTRL, 32'h0000_0211, q);
    scan(2, 3, 1'h0, 1'h1);
    bus(1'h1, `ACLS_REG_CTRL, 32'h0000_0204, q);
    slow <= 1'h0;
    chk_smp();
    chk("dyn_held", 32'h3, 32'(dyn_out));
    chk("unipolar", 32'h0, 32'(ai_bipolar));
    bus(1'h0, `ACLS_REG_STATUS, 32'h0, q);
    chk("cerr_idle", 32'h8, q & 32'h9);
  endtask

  task automatic test_resets();
    @(posedge clock);
    rst <= 1'h1;
    @(posedge clock);
    rst <= 1'h0;
    @(negedge clock);
    chk("dyn_after_rst", 32'h3, 32'(dyn_out));
    @(posedge clock);
    por <= 1'h1;
    @(posedge clock);
    por <= 1'h0;
    @(negedge clock);
    chk("dyn_after_por", 32'h0, 32'(dyn_out));
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Both resets are held together so the dynamic lines start known.
  initial
  begin
    rst = 1'h1;
    por = 1'h1;
    slow = 1'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = `ACLS_BE_ALL;
    sample_clk_n = 1'h1;
    dio_in = 16'hc3a5;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    por <= 1'h0;
    test_regs();
    test_triggered();
    test_continuous();
    test_resets();
    tally_and_finish();
  end

  // A hang counts as a failure.
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
endmodule

bind acls_seq acls_seq_properties #(.RES_BITS(RES_BITS)) u_props (.*);
